/* File: remap_ecap_map.svh */
// Offsets, field positions and reset values of the extended capability
// register. Included by the package and the register block.
`ifndef REMAP_ECAP_MAP_SVH
`define REMAP_ECAP_MAP_SVH

// Byte offsets of the two 32-bit words of the 64-bit register
`define ECAP_OFFSET_LO      8'h10
`define ECAP_OFFSET_HI      8'h14
`define ADDR_WIDTH          8

// Reset value of the whole register
`define ECAP_RESET          64'h0000_0000_0000_1000

// Field positions
`define HANDLE_MASK_MSB     23
`define HANDLE_MASK_LSB     20
`define INV_UNIT_OFFSET_MSB 17
`define INV_UNIT_OFFSET_LSB 8
`define SNOOP_CONTROL_BIT   7
`define PASSTHROUGH_BIT     6
`define CACHING_HINT_BIT    5
`define EXT_INTR_ID_BIT     4
`define INTR_REMAP_BIT      3
`define ENDPOINT_CACHE_BIT  2
`define QUEUED_INVAL_BIT    1
`define COHERENT_WALK_BIT   0

// Reserved spans inside the low word
`define RSVD_TOP_MSB        31
`define RSVD_TOP_LSB        24
`define RSVD_MID_MSB        19
`define RSVD_MID_LSB        18

// Field defaults
`define MAX_HANDLE_MASK_RST 4'h0
`define INV_UNIT_OFFSET_RST 10'h010
`define INV_UNIT_STRIDE     4

`endif

/* File: remap_ecap_pkg.sv */
// Types for the extended capability register of the remapping unit.
// Includes remap_ecap_map.svh, but writes its own widths out as numbers.
`include "remap_ecap_map.svh"

package remap_ecap_pkg;

  // Register bus request, one cycle per strobe
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } reg_req_t;

  // Feature bits, packed in register order from bit 23 down to bit 0
  typedef struct packed {
    logic [3:0]  max_handle_mask;
    logic [1:0]  reserved_19_18;
    logic [9:0]  invalidation_unit_offset;
    logic        snoop_control_support;
    logic        passthrough_support;
    logic        caching_hint_support;
    logic        extended_interrupt_id_mode;
    logic        interrupt_remap_support;
    logic        endpoint_translation_cache_support;
    logic        queued_invalidation_support;
    logic        coherent_walk;
  } ecap_fields_t;

endpackage

/* File: remap_extended_capability_report.sv */
// Read-only 64-bit extended capability register of a DMA remapping unit.
// Assumes a single-cycle register master on clock_in; read data stand in
// the cycle after the read strobe and only there.
//
// Functional notes
// - 64-bit read-only register at 10h-17h, reset value 1000h.
// - Bits 23:20 give largest handle mask, default 0, valid with remapping.
// - Bits 17:8 give invalidation unit offset 010h, unit at base+16*value.
// - Last invalidation unit sits at base+16*offset+16*unit count.
// - Bit 7 reports snoop control support for entry snoop field.
// - Bit 6 reports pass-through translation type support.
// - Bit 5 reports caching hints; zero makes hint fields reserved.
// - Bit 4 reports 32-bit extended interrupt IDs, valid with remapping.
// - Bit 3 reports interrupt remapping; one requires queued invalidation.
// - Bit 2 reports endpoint translation caches; one requires queued inval.
// - Bit 1 reports queued invalidation support.
// - Bit 0 reports coherent structure reads; fault log writes coherent.
`timescale 1ns/100ps
`include "remap_ecap_map.svh"

module remap_extended_capability_report
  import remap_ecap_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        write_in,
  input  wire logic        read_in,
  output logic      [31:0] rdata_out,
  // Derived invalidation unit placement, byte offsets from register base
  input  wire logic [7:0]  invalidation_unit_count_in,
  output logic      [15:0] first_inv_unit_addr_out,
  output logic      [15:0] last_inv_unit_addr_out
);

  // Bus request gathered into one carrier
  reg_req_t    req;
  assign req = '{addr: addr_in, wdata: wdata_in,
                 write: write_in, read: read_in};

  // Capability fields; fixed by construction, so no flop can be upset.
  // Remapping and endpoint caches each need queued invalidation, so the
  // three stay zero together: raising either of the first two alone breaks a rule. Handle
  // mask and extended ID width mean nothing while remapping reads zero.
  ecap_fields_t fields;
  assign fields.max_handle_mask = `MAX_HANDLE_MASK_RST;
  assign fields.reserved_19_18 = 2'h0;
  assign fields.invalidation_unit_offset = `INV_UNIT_OFFSET_RST;
  assign fields.snoop_control_support = 1'b0;
  assign fields.passthrough_support = 1'b0;
  assign fields.caching_hint_support = 1'b0;
  assign fields.extended_interrupt_id_mode = 1'b0;
  assign fields.interrupt_remap_support = 1'b0;
  assign fields.endpoint_translation_cache_support = 1'b0;
  assign fields.queued_invalidation_support = 1'b0;
  assign fields.coherent_walk = 1'b0;

  // Full register image; upper 40 bits reserved zero
  logic [63:0] ecap_image;
  assign ecap_image = {40'h00_0000_0000, fields};

  // Address decode; unmapped addresses read zero
  logic        hit_lo;
  logic        hit_hi;
  logic [31:0] next_rdata;
  assign hit_lo = (req.addr == `ECAP_OFFSET_LO);
  assign hit_hi = (req.addr == `ECAP_OFFSET_HI);
  assign next_rdata = !req.read ? 32'h0000_0000 :
                      hit_lo    ? ecap_image[31:0] :
                      hit_hi    ? ecap_image[63:32] : 32'h0000_0000;

  // Invalidation unit placement: stride of 16 bytes per unit
  logic [15:0] next_first;
  logic [15:0] next_last;
  assign next_first = {2'h0, fields.invalidation_unit_offset, 4'h0};
  assign next_last  = next_first
                    + {4'h0, invalidation_unit_count_in, 4'h0};

  // Read data register; writes are ignored since nothing stores them
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // Placement outputs registered to keep outputs flop-driven
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      first_inv_unit_addr_out <= 16'h0000;
      last_inv_unit_addr_out  <= 16'h0000;
    end else begin
      first_inv_unit_addr_out <= next_first;
      last_inv_unit_addr_out  <= next_last;
    end
  end

  // Helper: past_valid rises at the first edge after reset is released
  logic past_valid;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      past_valid <= 1'b0;
    end else begin
      past_valid <= 1'b1;
    end
  end

  // Independent decode for the checks below, so a broken hit_lo or
  // hit_hi cannot hide behind the very logic it is meant to judge
  logic probe_read_low;
  logic probe_read_high;
  logic probe_read_other;
  assign probe_read_low   = read_in && (addr_in == `ECAP_OFFSET_LO);
  assign probe_read_high  = read_in && (addr_in == `ECAP_OFFSET_HI);
  assign probe_read_other = read_in && !probe_read_low && !probe_read_high;

  chk_low_word_read: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (read_in && addr_in == 8'h10) |=> rdata_out == 32'h0000_1000)
    else $error("low word of capability register wrong");

  chk_high_word_zero: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (read_in && addr_in == 8'h14) |=> rdata_out == 32'h0000_0000)
    else $error("high word of capability register not zero");

  chk_handle_mask_zero: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (read_in && addr_in == 8'h10) |=> rdata_out[23:20] == 4'h0)
    else $error("handle mask field not default");

  chk_offset_field: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (read_in && addr_in == 8'h10) |=> rdata_out[17:8] == 10'h010)
    else $error("invalidation unit offset wrong");

  chk_first_unit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    past_valid |-> first_inv_unit_addr_out == 16'h0100)
    else $error("first invalidation unit address wrong");

  chk_last_unit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    past_valid |=> last_inv_unit_addr_out ==
      16'h0100 + {4'h0, $past(invalidation_unit_count_in), 4'h0})
    else $error("last invalidation unit address wrong");

  chk_feature_bits: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (read_in && addr_in == 8'h10) |=> rdata_out[7:0] == 8'h00)
    else $error("feature bits not at default");

  chk_queued_inval_dep: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (fields.interrupt_remap_support
     || fields.endpoint_translation_cache_support)
    |-> fields.queued_invalidation_support)
    else $error("remap or endpoint cache without queued invalidation");

  chk_write_ignored: assert property (
    @(posedge clock_in) disable iff (reset_in)
    write_in ##1 (read_in && addr_in == 8'h10)
    |=> rdata_out == 32'h0000_1000)
    else $error("write altered capability register");

  chk_idle_zero: assert property (
    @(posedge clock_in) disable iff (reset_in)
    !read_in |=> rdata_out == 32'h0000_0000)
    else $error("read data not zero outside read answer");

  // Each feature bit on its own, so a failure names the field at fault
  chk_snoop_ctrl_bit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> !rdata_out[`SNOOP_CONTROL_BIT])
    else $error("snoop control support bit set");

  // Pass-through stays unsupported; software must not pick that type
  chk_passthrough_bit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> !rdata_out[`PASSTHROUGH_BIT])
    else $error("pass-through support bit set");

  // No hints, so allocation and eviction hint fields stay reserved
  chk_cache_hint_bit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> !rdata_out[`CACHING_HINT_BIT])
    else $error("caching hint support bit set");

  // Legacy 8-bit interrupt IDs only
  chk_ext_id_bit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> !rdata_out[`EXT_INTR_ID_BIT])
    else $error("extended interrupt ID bit set");

  // Interrupt remapping is not offered by this unit
  chk_remap_bit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> !rdata_out[`INTR_REMAP_BIT])
    else $error("interrupt remap support bit set");

  // No translation caches on the endpoint side
  chk_endpoint_cache_bit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> !rdata_out[`ENDPOINT_CACHE_BIT])
    else $error("endpoint translation cache bit set");

  // Queued invalidation is not offered
  chk_queued_inval_bit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> !rdata_out[`QUEUED_INVAL_BIT])
    else $error("queued invalidation bit set");

  // Structure reads are reported as non-snooped
  chk_coherent_walk_bit: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> !rdata_out[`COHERENT_WALK_BIT])
    else $error("coherent walk bit set");

  // Remapping reported without queued invalidation would be illegal
  chk_remap_needs_queue: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> (!rdata_out[`INTR_REMAP_BIT]
                        || rdata_out[`QUEUED_INVAL_BIT]))
    else $error("remap support without queued invalidation");

  // The same holds for translation caches in endpoints
  chk_endpoint_needs_queue: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> (!rdata_out[`ENDPOINT_CACHE_BIT]
                        || rdata_out[`QUEUED_INVAL_BIT]))
    else $error("endpoint caches without queued invalidation");

  // Reserved bits 19:18 of the low word read zero
  chk_reserved_mid: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> rdata_out[`RSVD_MID_MSB:`RSVD_MID_LSB] == 2'h0)
    else $error("reserved bits 19:18 not zero");

  // Reserved bits 31:24 of the low word read zero
  chk_reserved_top: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low |=> rdata_out[`RSVD_TOP_MSB:`RSVD_TOP_LSB] == 8'h00)
    else $error("reserved bits 31:24 not zero");

  // Any address outside the register pair answers zero
  chk_unmapped_zero: assert property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_other |=> rdata_out == 32'h0000_0000)
    else $error("unmapped address read not zero");

  // A write alone leaves nothing on the read data lines
  chk_write_silent: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (write_in && !read_in) |=> rdata_out == 32'h0000_0000)
    else $error("write produced read data");

  // Reset drives every output to zero at the next edge, read or not
  chk_reset_clears: assert property (
    @(posedge clock_in)
    reset_in |=> (rdata_out == 32'h0000_0000
                  && first_inv_unit_addr_out == 16'h0000
                  && last_inv_unit_addr_out == 16'h0000))
    else $error("outputs not cleared by reset");

  // Offset is fixed, so the first unit address never moves after reset
  chk_first_stable: assert property (
    @(posedge clock_in) disable iff (reset_in)
    past_valid |=> $stable(first_inv_unit_addr_out))
    else $error("first invalidation unit address moved");

  // The last unit never sits below the first; a wrap would break this
  chk_last_order: assert property (
    @(posedge clock_in) disable iff (reset_in)
    past_valid |-> last_inv_unit_addr_out >= first_inv_unit_addr_out)
    else $error("last invalidation unit below first");

  // The assembled image must equal the fixed reset value
  chk_image_value: assert property (
    @(posedge clock_in) disable iff (reset_in)
    ecap_image == `ECAP_RESET)
    else $error("register image differs from its fixed value");

  cov_read_low: cover property (
    @(posedge clock_in) disable iff (reset_in)
    read_in && addr_in == 8'h10);

  cov_read_high: cover property (
    @(posedge clock_in) disable iff (reset_in)
    read_in && addr_in == 8'h14);

  cov_write_then_read: cover property (
    @(posedge clock_in) disable iff (reset_in)
    (write_in && addr_in == 8'h10) ##1 (read_in && addr_in == 8'h10));

  // Reads of both words with no gap between the strobes
  cov_back_to_back: cover property (
    @(posedge clock_in) disable iff (reset_in)
    probe_read_low ##1 probe_read_high);

  // A write of all ones, the value most likely to leave a trace
  cov_write_ones: cover property (
    @(posedge clock_in) disable iff (reset_in)
    req.write && req.wdata == 32'hFFFF_FFFF);

endmodule

/* File: tb_top.sv */
// Self-checking bench for the extended capability register block.
// Assumes a single-cycle register master and one 40 MHz clock.
`timescale 1ns/100ps
`include "remap_ecap_map.svh"

module tb_top
  import remap_ecap_pkg::*;
;
  logic        clock_in;
  logic        reset_in;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        write;
  logic        read;
  logic [31:0] rdata;
  logic [7:0]  count;
  logic [15:0] first_addr;
  logic [15:0] last_addr;
  logic [31:0] d;
  int          n_fail;
  int          cmp_count;
  // Ordinary read rows: address beside the word it must return
  logic [7:0]  row_addr [6] = '{8'h10, 8'h14, 8'h00, 8'h18, 8'h0C, 8'hFF};
  logic [31:0] row_exp  [6] = '{32'h0000_1000, 32'h0, 32'h0, 32'h0, 32'h0,
                                32'h0};

  remap_extended_capability_report dut_u (
    .clock_in                   (clock_in),
    .reset_in                   (reset_in),
    .addr_in                    (addr),
    .wdata_in                   (wdata),
    .write_in                   (write),
    .read_in                    (read),
    .rdata_out                  (rdata),
    .invalidation_unit_count_in (count),
    .first_inv_unit_addr_out    (first_addr),
    .last_inv_unit_addr_out     (last_addr)
  );

  // Free-running 25 ns clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle read; the answer is taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clock_in) begin addr <= a; read <= 1'b1; end
    @(posedge clock_in) read <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run needs well under 200 cycles; this bound catches a hang
  initial begin
    #(25 * 2000);
    n_fail++;
    summarize();
  end

  initial begin
    n_fail = 0; cmp_count = 0; reset_in = 1'b1; addr = 8'h00;
    wdata = 32'h0; write = 1'b0; read = 1'b0; count = 8'h00;
    repeat (2) @(posedge clock_in);
    #1 cmp("rst rdata", 32'h0, rdata);
    cmp("rst first", 32'h0, first_addr);
    @(posedge clock_in) reset_in <= 1'b0;
    @(posedge clock_in) #1 cmp("first", 32'h0100, first_addr);
    cmp("last at zero", 32'h0100, last_addr);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      rd(row_addr[i], d);
      cmp("row read", row_exp[i], d);
      @(posedge clock_in) #1 cmp("rdata idle", 32'h0, rdata);
    end
    $display("test reads done");
    rd(`ECAP_OFFSET_LO, d);
    cmp("handle mask", 32'h0, d[23:20]);
    cmp("unit offset", 32'h010, d[17:8]);
    cmp("bits 7:4", 32'h0, d[7:4]);
    cmp("bits 3:0", 32'h0, d[3:0]);
    cmp("rsvd", 32'h0, {d[31:24], d[19:18]});
    $display("test fields done");
    // Writes of all ones to both words, then read back at once
    @(posedge clock_in) begin
      addr <= `ECAP_OFFSET_HI; wdata <= 32'hFFFF_FFFF; write <= 1'b1;
    end
    @(posedge clock_in) addr <= `ECAP_OFFSET_LO;
    @(posedge clock_in) begin write <= 1'b0; read <= 1'b1; end
    @(posedge clock_in) read <= 1'b0;
    #1 cmp("lo after wr", 32'h0000_1000, rdata);
    rd(`ECAP_OFFSET_HI, d);
    cmp("hi after wr", 32'h0, d);
    $display("test writes done");
    // Back-to-back reads with no gap, low word then high word
    @(posedge clock_in) begin addr <= `ECAP_OFFSET_LO; read <= 1'b1; end
    @(posedge clock_in) addr <= `ECAP_OFFSET_HI;
    #1 cmp("b2b lo", 32'h0000_1000, rdata);
    @(posedge clock_in) read <= 1'b0;
    #1 cmp("b2b hi", 32'h0, rdata);
    @(posedge clock_in) #1 cmp("b2b idle", 32'h0, rdata);
    $display("test back to back done");
    // Unit counts at both ends of the range and between
    foreach (row_addr[i]) begin
      @(posedge clock_in) count <= row_addr[i];
      @(posedge clock_in) #1;
      @(posedge clock_in) #1;
      cmp("last", 32'h0100 + 16 * row_addr[i], last_addr);
      cmp("first", 32'h0100, first_addr);
    end
    $display("test placement done");
    // Reset in mid-run clears outputs, then the register reads again
    @(posedge clock_in) begin reset_in <= 1'b1; read <= 1'b1; end
    @(posedge clock_in) read <= 1'b0;
    @(posedge clock_in) #1 cmp("rst last", 32'h0, last_addr);
    cmp("rst rd", 32'h0, rdata);
    cmp("mid rst first", 32'h0, first_addr);
    @(posedge clock_in) reset_in <= 1'b0;
    rd(`ECAP_OFFSET_LO, d);
    cmp("lo after rst", 32'h0000_1000, d);
    cmp("first after rst", 32'h0100, first_addr);
    $display("test second reset done");
    summarize();
  end
endmodule
